// ===== verilog/usb_event_status_flags.sv
// USB event status block: sticky event flags, mask, interrupt, reset output
// and an AXI4-Lite slave giving software access to them.
// Assumes all event inputs are synchronous to clk, pulses last one cycle.
//
// Contract
// RULE1 - Reset output follows bus reset when enabled
// RULE2 - Bus reset sets flag, resets USB logic
// RULE3 - Suspend detect sets bit 6
// RULE4 - Resume detect sets bit 5
// RULE5 - Every host frame sets bit 4
// RULE6 - Unlocked timer sets pseudo frame bit 3
// RULE7 - Pseudo frames every nominal 1 ms
// RULE8 - Completed setup stage sets bit 2
// RULE9 - Setup buffer overwrite sets bit 0
// RULE10 - Overwrite: new setup before old completes
// RULE11 - Vector register write clears all flags
// RULE12 - Status writes never change flags
// RULE13 - Reserved bit 1 always reads zero
// RULE14 - Interrupt only for masked-in flags
//
// Design decisions made here: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
module usb_event_status_flags #(
  parameter int PSEUDO_FRAME_FLAG_PERIOD_CYCLES = usb_event_pkg::PSEUDO_FRAME_FLAG_CYCLES  // Pseudo frame period
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        nrst,
  // AXI4-Lite write address
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Events from serial engine, frame logic and suspend/resume logic
  input  wire logic        busResetActive,   // Level, high during bus reset
  input  wire logic        suspendDetect,    // Pulse, suspend condition
  input  wire logic        resumeDetect,     // Pulse, resume condition
  input  wire logic        hostSofDetect,    // Pulse, host frame packet
  input  wire logic        frameLocked,      // Level, timer locked to host
  input  wire logic        setupDone,        // Pulse, setup stage completed
  input  wire logic        controlDone,      // Pulse, control transfer ended
  // Outputs to the rest of the device
  output logic             usbLogicReset,    // Resets engine, buffers, timer
  output logic             resetOutputPin,   // Device reset output, high active
  output logic             irq               // Level interrupt
);

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  logic [7:0]  mask_reg;          // Interrupt mask
  logic [7:0]  mask_next;
  logic        frstEn_reg;        // Function reset enable
  logic        frstEn_next;
  logic        rstSeen_reg;       // Bus reset level, one cycle late
  logic        rstSeen_next;
  logic        rstPin_reg;        // Registered reset output
  logic        rstPin_next;
  logic        xferOpen_reg;      // Control transfer under way
  logic        xferOpen_next;
  logic        awHeld_reg;        // Write address captured
  logic        awHeld_next;
  logic [3:0]  awAddr_reg;
  logic [3:0]  awAddr_next;
  logic        wHeld_reg;         // Write data captured
  logic        wHeld_next;
  logic [31:0] wData_reg;
  logic [31:0] wData_next;
  logic [3:0]  wStrb_reg;
  logic [3:0]  wStrb_next;
  logic        bValid_reg;
  logic        bValid_next;
  logic [1:0]  bResp_reg;
  logic [1:0]  bResp_next;
  logic        rValid_reg;
  logic        rValid_next;
  logic [31:0] rData_reg;
  logic [31:0] rData_next;
  logic [1:0]  rResp_reg;
  logic [1:0]  rResp_next;

  logic        busResetRise;      // First cycle of a bus reset
  logic        pseudoSof;         // From frame timer
  logic        overwrite;         // Setup buffer overwritten
  logic        doWrite;           // Both write halves present
  logic        doRead;            // Read address taken
  logic        vectorWrite;       // Clears every flag
  logic        statusRead;        // Read of status clears it
  logic        clearFlags;
  logic [7:0]  setPulse;
  logic [7:0]  flags;
  logic [3:0]  arAddr;

  // ----------------------------------------------------------------------
  // Event conditioning
  // ----------------------------------------------------------------------
  // Edge of bus reset sets the flag once per reset, not every cycle
  assign busResetRise = busResetActive & ~rstSeen_reg;  // [RULE2]
  // New setup landing while the previous transfer is still open
  assign overwrite    = setupDone & xferOpen_reg;       // [RULE10]

  // Flag set vector, reserved position held at zero
  always_comb begin
    setPulse                              = '0;
    setPulse[usb_event_pkg::BIT_BUS_RST]  = busResetRise;   // [RULE2]
    setPulse[usb_event_pkg::BIT_SUSPEND]  = suspendDetect;  // [RULE3]
    setPulse[usb_event_pkg::BIT_RESUME]   = resumeDetect;   // [RULE4]
    setPulse[usb_event_pkg::BIT_SOF]      = hostSofDetect;  // Even unlocked [RULE5]
    setPulse[usb_event_pkg::BIT_PSEUDO_FRAME_FLAG]     = pseudoSof;      // [RULE6]
    setPulse[usb_event_pkg::BIT_SETUP]    = setupDone;      // [RULE8]
    setPulse[usb_event_pkg::BIT_SETUP_OVERWRITE_FLAG]    = overwrite;      // [RULE9]
  end

  // Transfer tracker and reset edge
  always_comb begin
    rstSeen_next  = busResetActive;
    xferOpen_next = xferOpen_reg;
    if (busResetActive) begin
      // Bus reset abandons any transfer in flight
      xferOpen_next = 1'b0;
    end else if (setupDone) begin
      xferOpen_next = 1'b1;
    end else if (controlDone) begin
      xferOpen_next = 1'b0;
    end
  end

  // Reset output follows bus reset only while enabled
  always_comb begin
    rstPin_next = frstEn_reg & busResetActive;  // [RULE1]
  end

  // ----------------------------------------------------------------------
  // Submodules
  // ----------------------------------------------------------------------
  // Local frame timer, restarted by bus reset
  frame_timer #(
    .PERIOD_CYCLES (PSEUDO_FRAME_FLAG_PERIOD_CYCLES)
  ) u_frame_timer (
    .clk         (clk),
    .nrst        (nrst),
    .restart     (busResetActive),   // [RULE2]
    .hostSof     (hostSofDetect),
    .frameLocked (frameLocked),
    .pseudoSof   (pseudoSof)
  );

  // Sticky status flags
  event_flag_bank #(
    .WIDTH (usb_event_pkg::FLAG_W),
    .LIVE  (usb_event_pkg::LIVE_BITS)
  ) u_flags (
    .clk      (clk),
    .nrst     (nrst),
    .setPulse (setPulse),
    .clearAll (clearFlags),
    .flags    (flags)
  );

  // ----------------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------------
  assign arAddr      = s_axi_araddr[3:0];
  assign doWrite     = awHeld_reg & wHeld_reg & ~bValid_reg;
  assign doRead      = s_axi_arvalid & s_axi_arready;
  assign vectorWrite = doWrite & (awAddr_reg == usb_event_pkg::OFS_VECTOR);  // [RULE11]
  assign statusRead  = doRead & (arAddr == usb_event_pkg::OFS_STATUS);
  // A status offset write is accepted but feeds no flag clear [RULE12]
  assign clearFlags  = vectorWrite | statusRead;

  // Write channel capture and register update
  always_comb begin
    awHeld_next = awHeld_reg;
    awAddr_next = awAddr_reg;
    wHeld_next  = wHeld_reg;
    wData_next  = wData_reg;
    wStrb_next  = wStrb_reg;
    bValid_next = bValid_reg;
    bResp_next  = bResp_reg;
    mask_next   = mask_reg;
    frstEn_next = frstEn_reg;
    // Address and data are taken independently, in either order
    if (s_axi_awvalid && s_axi_awready) begin
      awHeld_next = 1'b1;
      awAddr_next = s_axi_awaddr[3:0];
    end
    if (s_axi_wvalid && s_axi_wready) begin
      wHeld_next = 1'b1;
      wData_next = s_axi_wdata;
      wStrb_next = s_axi_wstrb;
    end
    if (doWrite) begin
      awHeld_next = 1'b0;
      wHeld_next  = 1'b0;
      bValid_next = 1'b1;
      bResp_next  = usb_event_pkg::RESP_OKAY;
      case (awAddr_reg)
        usb_event_pkg::OFS_STATUS: begin
          // Accepted but ignored, flags are read-only [RULE12]
        end
        usb_event_pkg::OFS_MASK: begin
          if (wStrb_reg[0]) begin
            mask_next = wData_reg[7:0] & usb_event_pkg::LIVE_BITS;  // [RULE13]
          end
        end
        usb_event_pkg::OFS_CONTROL: begin
          if (wStrb_reg[0]) begin
            frstEn_next = wData_reg[usb_event_pkg::BIT_FRST_EN];
          end
        end
        usb_event_pkg::OFS_VECTOR: begin
          // Data ignored, the write itself clears the flags
        end
        default: begin
          bResp_next = usb_event_pkg::RESP_SLVERR;  // Unmapped
        end
      endcase
    end else if (bValid_reg && s_axi_bready) begin
      bValid_next = 1'b0;
    end
  end

  // Read channel, data registered at address handshake
  always_comb begin
    rValid_next = rValid_reg;
    rData_next  = rData_reg;
    rResp_next  = rResp_reg;
    if (doRead) begin
      rValid_next = 1'b1;
      rData_next  = '0;
      rResp_next  = usb_event_pkg::RESP_OKAY;
      case (arAddr)
        usb_event_pkg::OFS_STATUS:  rData_next[7:0] = flags;    // Bit 1 is zero [RULE13]
        usb_event_pkg::OFS_MASK:    rData_next[7:0] = mask_reg;
        usb_event_pkg::OFS_CONTROL: rData_next[usb_event_pkg::BIT_FRST_EN] = frstEn_reg;
        usb_event_pkg::OFS_VECTOR:  rData_next[7:0] = flags & mask_reg;
        default:                    rResp_next = usb_event_pkg::RESP_SLVERR;
      endcase
    end else if (rValid_reg && s_axi_rready) begin
      rValid_next = 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mask_reg     <= usb_event_pkg::MASK_RESET;
      frstEn_reg   <= usb_event_pkg::CTRL_RESET;
      rstSeen_reg  <= 1'b0;
      rstPin_reg   <= 1'b0;
      xferOpen_reg <= 1'b0;
      awHeld_reg   <= 1'b0;
      awAddr_reg   <= '0;
      wHeld_reg    <= 1'b0;
      wData_reg    <= '0;
      wStrb_reg    <= '0;
      bValid_reg   <= 1'b0;
      bResp_reg    <= usb_event_pkg::RESP_OKAY;
      rValid_reg   <= 1'b0;
      rData_reg    <= '0;
      rResp_reg    <= usb_event_pkg::RESP_OKAY;
    end else begin
      mask_reg     <= mask_next;
      frstEn_reg   <= frstEn_next;
      rstSeen_reg  <= rstSeen_next;
      rstPin_reg   <= rstPin_next;
      xferOpen_reg <= xferOpen_next;
      awHeld_reg   <= awHeld_next;
      awAddr_reg   <= awAddr_next;
      wHeld_reg    <= wHeld_next;
      wData_reg    <= wData_next;
      wStrb_reg    <= wStrb_next;
      bValid_reg   <= bValid_next;
      bResp_reg    <= bResp_next;
      rValid_reg   <= rValid_next;
      rData_reg    <= rData_next;
      rResp_reg    <= rResp_next;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  // One outstanding write: halves refused until the response is taken
  assign s_axi_awready = ~awHeld_reg & ~bValid_reg;
  assign s_axi_wready  = ~wHeld_reg & ~bValid_reg;
  assign s_axi_bvalid  = bValid_reg;
  assign s_axi_bresp   = bResp_reg;
  assign s_axi_arready = ~rValid_reg;
  assign s_axi_rvalid  = rValid_reg;
  assign s_axi_rdata   = rData_reg;
  assign s_axi_rresp   = rResp_reg;
  // Held for the whole bus reset so downstream blocks stay reset [RULE2]
  assign usbLogicReset = rstSeen_reg;
  assign resetOutputPin = rstPin_reg;  // [RULE1]
  // Level interrupt from unmasked flags only [RULE14]
  assign irq = |(flags & mask_reg);

endmodule : usb_event_status_flags

// ===== verilog/usb_event_pkg.sv
// Shared constants: register map, bit layout, responses, frame timing.
// Assumes a single 50 MHz device clock shared by every user of this package.
package usb_event_pkg;

  // ----------------------------------------------------------------------
  // Register map (byte addresses, one aligned word each)
  // ----------------------------------------------------------------------
  localparam int          ADDR_W        = 4;       // Decoded address width
  localparam logic [3:0]  OFS_STATUS    = 4'h0;    // Event status, read-only
  localparam logic [3:0]  OFS_MASK      = 4'h4;    // Interrupt mask
  localparam logic [3:0]  OFS_CONTROL   = 4'h8;    // Control bits
  localparam logic [3:0]  OFS_VECTOR    = 4'hc;    // Interrupt vector, write clears

  // ----------------------------------------------------------------------
  // Status and mask bit layout
  // ----------------------------------------------------------------------
  localparam int FLAG_W      = 8;   // Width of status and mask
  localparam int BIT_BUS_RST = 7;   // Bus reset seen
  localparam int BIT_SUSPEND = 6;   // Suspend seen
  localparam int BIT_RESUME  = 5;   // Resume seen
  localparam int BIT_SOF     = 4;   // Host start-of-frame
  localparam int BIT_PSEUDO_FRAME_FLAG    = 3;   // Pseudo start-of-frame
  localparam int BIT_SETUP   = 2;   // Setup stage done
  localparam int BIT_RSVD    = 1;   // Reserved, reads zero
  localparam int BIT_SETUP_OVERWRITE_FLAG   = 0;   // Setup buffer overwritten

  localparam logic [7:0] FLAG_RESET   = 8'h00;  // Flags after reset
  localparam logic [7:0] MASK_RESET   = 8'h00;  // Mask after reset
  localparam logic [7:0] LIVE_BITS    = 8'hfd;  // All but the reserved bit
  localparam int         BIT_FRST_EN  = 0;      // Control: reset output enable
  localparam logic       CTRL_RESET   = 1'b0;   // Control after reset

  // ----------------------------------------------------------------------
  // AXI4-Lite responses
  // ----------------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY    = 2'h0;
  localparam logic [1:0] RESP_SLVERR  = 2'h2;

  // ----------------------------------------------------------------------
  // Frame timing
  // ----------------------------------------------------------------------
  localparam int CLK_FREQ_KHZ   = 50000;  // Device clock, 50 MHz
  localparam int PSEUDO_FRAME_FLAG_PERIOD_MS = 1;      // Nominal pseudo frame period
  localparam int PSEUDO_FRAME_FLAG_CYCLES    = PSEUDO_FRAME_FLAG_PERIOD_MS * CLK_FREQ_KHZ;

endpackage : usb_event_pkg

// ===== verilog/frame_timer.sv
// Free-running local frame timer that makes pseudo start-of-frame pulses.
// Assumes host frame pulses are synchronous one-cycle pulses; restart is a synchronous level held for the bus reset.
`timescale 1ns/1ps
module frame_timer #(
  parameter int PERIOD_CYCLES = usb_event_pkg::PSEUDO_FRAME_FLAG_CYCLES
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic nrst,
  // Control
  input  wire logic restart,       // Bus reset returns timer to start
  input  wire logic hostSof,       // Host frame realigns the count
  input  wire logic frameLocked,   // Timer tracks host frames
  // Event out
  output logic      pseudoSof      // One-cycle pseudo frame pulse
);

  localparam int CW = $clog2(PERIOD_CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(PERIOD_CYCLES - 1);

  logic [CW-1:0] count_reg;   // Cycles into current frame
  logic [CW-1:0] count_next;
  logic          pulse_reg;   // Registered pseudo frame pulse
  logic          pulse_next;

  // ----------------------------------------------------------------------
  // Next count and pulse
  // ----------------------------------------------------------------------
  always_comb begin
    count_next = count_reg + 1'b1;
    pulse_next = 1'b0;
    if (restart || hostSof) begin
      // Host frame restarts the period so no pseudo frame doubles it
      count_next = '0;
    end else if (count_reg == LAST) begin
      count_next = '0;
      pulse_next = !frameLocked;   // Only artificial while unlocked [RULE6] [RULE7]
    end
  end

  // Registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      count_reg <= '0;
      pulse_reg <= 1'b0;
    end else begin
      count_reg <= count_next;
      pulse_reg <= pulse_next;
    end
  end

  assign pseudoSof = pulse_reg;

endmodule : frame_timer

// ===== verilog/event_flag_bank.sv
// Bank of sticky event flags, one per live bit, with a common clear.
// Assumes set pulses and clear are synchronous to clk.
`timescale 1ns/1ps
module event_flag_bank #(
  parameter int                WIDTH = usb_event_pkg::FLAG_W,
  parameter logic [WIDTH-1:0]  LIVE  = usb_event_pkg::LIVE_BITS
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             nrst,
  // Events
  input  wire logic [WIDTH-1:0] setPulse,   // Hardware event per bit
  input  wire logic             clearAll,   // Software clear of every bit
  // State
  output logic      [WIDTH-1:0] flags       // Sticky flag values
);

  logic [WIDTH-1:0] flag_reg;
  logic [WIDTH-1:0] flag_next;

  // ----------------------------------------------------------------------
  // One sticky cell per live bit, reserved bits tied to zero
  // ----------------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_flag
      if (LIVE[i]) begin : g_live
        // Set beats clear so an event in the clearing cycle survives
        always_comb begin
          flag_next[i] = setPulse[i] | (flag_reg[i] & ~clearAll);
        end
      end else begin : g_rsvd
        // Reserved position never holds a one [RULE13]
        always_comb begin
          flag_next[i] = 1'b0;
        end
      end
    end
  endgenerate

  // Registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      flag_reg <= '0;
    end else begin
      flag_reg <= flag_next;
    end
  end

  assign flags = flag_reg;

endmodule : event_flag_bank

// ===== bench/usb_event_status_flags_properties.sv
// Checker: bus timing, reserved bits, reset pins and interrupt causes.
// Assumes one clock domain; bound to every instance of the top module.
`timescale 1ns/1ps
module usb_event_status_flags_properties #(
  parameter int PSEUDO_FRAME_FLAG_PERIOD_CYCLES = 20  // Pseudo frame period
) (
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic [31:0] s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        busResetActive,
  input wire logic        suspendDetect,
  input wire logic        resumeDetect,
  input wire logic        hostSofDetect,
  input wire logic        frameLocked,
  input wire logic        setupDone,
  input wire logic        usbLogicReset,
  input wire logic        resetOutputPin,
  input wire logic        irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  // Any hardware event that may set a flag this cycle
  wire anyEvent = suspendDetect | resumeDetect | hostSofDetect | setupDone | busResetActive;

  // ----------------------------------------
  // Bus steps
  // ----------------------------------------
  sequence seqWrTaken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence seqRdTaken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  // Status read on a quiet cycle, timer locked so no pseudo frame
  sequence seqQuietStatusRd;
    seqRdTaken ##0 (s_axi_araddr[3:0] == usb_event_pkg::OFS_STATUS && !anyEvent && frameLocked);
  endsequence

  chk_wr_answer: assert property (seqWrTaken |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");
  chk_rd_answer: assert property (seqRdTaken |=> s_axi_rvalid)
    else $error("read data late");
  chk_rd_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  chk_rsvd_zero: assert property (s_axi_rvalid |-> s_axi_rdata[1] == 1'b0 && s_axi_rdata[31:8] == 24'h0)
    else $error("reserved read bits not zero");
  chk_logic_reset: assert property ($rose(busResetActive) |=> usbLogicReset)
    else $error("usb logic reset missing");
  chk_pin_cause: assert property (resetOutputPin |-> $past(busResetActive) && usbLogicReset)
    else $error("reset output without bus reset");
  chk_read_clears: assert property (seqQuietStatusRd |=> !irq)
    else $error("interrupt not cleared");
  chk_irq_cause: assert property ($rose(irq) |-> $past(anyEvent) || !$past(frameLocked) || s_axi_bvalid)
    else $error("interrupt without a cause");
endmodule : usb_event_status_flags_properties

bind usb_event_status_flags usb_event_status_flags_properties #(
  .PSEUDO_FRAME_FLAG_PERIOD_CYCLES(PSEUDO_FRAME_FLAG_PERIOD_CYCLES)) chk (.*);

// ===== bench/usb_event_source.sv
// Partner model: USB-side event sources (engine, frame and suspend logic).
// Assumes the bench calls its tasks from one process only.
`timescale 1ns/1ps
module usb_event_source (
  // Clock
  input  wire logic clk,
  // Event lines toward the block
  output logic      busResetActive,
  output logic      suspendDetect,
  output logic      resumeDetect,
  output logic      hostSofDetect,
  output logic      frameLocked,
  output logic      setupDone,
  output logic      controlDone
);
  logic [4:0] pls = 5'h0;  // Pulse lines: 4 suspend .. 0 setup
  assign {suspendDetect, resumeDetect, hostSofDetect, controlDone, setupDone} = pls;
  // Quiet bus, timer locked, at time zero
  initial begin
    busResetActive = 1'b0;
    frameLocked = 1'b1;
  end
  // One-cycle pulse; two setups with no done between model an abandoned transfer
  task automatic fire(input int n);
    @(posedge clk);
    pls[n] <= 1'b1;
    @(posedge clk);
    pls <= 5'h0;
  endtask : fire
  // Bus reset level, held until the bench lowers it
  task automatic setBusReset(input logic v);
    @(posedge clk);
    busResetActive <= v;
  endtask : setBusReset
  // Lock of the local timer to host frames
  task automatic setLock(input logic v);
    @(posedge clk);
    frameLocked <= v;
  endtask : setLock
endmodule : usb_event_source

// ===== bench/tb_top.sv
// Testbench: register accesses and event sequences.
// Assumes the checker is bound; partner model drives the USB-side events.
`timescale 1ns/1ps
module tb_top;
  localparam int PERIOD = 20;  // Short pseudo frame period
  logic        clk, nrst, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, usbLogicReset, resetOutputPin, irq;
  logic        busResetActive, suspendDetect, resumeDetect, hostSofDetect, frameLocked;
  logic        setupDone, controlDone;
  logic [3:0]  wstrb;
  logic [31:0] awaddr, wdata, araddr, rdata, rd;
  logic [1:0]  bresp, rresp, rs;
  int          nMismatch, numChecks;
  int          evIdx[3] = '{4, 3, 2};  // Suspend, resume, host frame
  int          evBit[3] = '{usb_event_pkg::BIT_SUSPEND, usb_event_pkg::BIT_RESUME,
                            usb_event_pkg::BIT_SOF};

  usb_event_status_flags #(.PSEUDO_FRAME_FLAG_PERIOD_CYCLES(PERIOD)) DUT (.clk, .nrst,
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .busResetActive, .suspendDetect, .resumeDetect, .hostSofDetect,
    .frameLocked, .setupDone, .controlDone, .usbLogicReset, .resetOutputPin, .irq);
  usb_event_source PM (.*);

  // ----------------------------------------
  // Clock, reset, watchdog
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Generous bound: the tests need well under 2000 cycles
  initial begin
    repeat (20000) @(posedge clk);
    nMismatch++;
    giveVerdict();
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    numChecks++;
    if (got !== exp) begin
      nMismatch++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask : check
  // Address and data offered together, each released when taken
  task automatic axiWrite(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
    bit awOk = 0;
    bit wOk = 0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (!awOk && awready) begin
        awOk = 1;
        awvalid <= 1'b0;
      end
      if (!wOk && wready) begin
        wOk = 1;
        wvalid <= 1'b0;
      end
    end while (!(awOk && wOk));
    do @(posedge clk); while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask : axiWrite
  task automatic axiRead(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (!arready);
    arvalid <= 1'b0;
    while (!rvalid) @(posedge clk);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : axiRead
  // Read status and compare both data and an OKAY response
  task automatic expectStatus(input logic [31:0] exp);
    axiRead({28'h0, usb_event_pkg::OFS_STATUS}, rd, rs);
    check("status", exp, rd);
    check("status resp", {30'h0, usb_event_pkg::RESP_OKAY}, {30'h0, rs});
  endtask : expectStatus
  task automatic giveVerdict();
    $display("checks %0d mismatches %0d", numChecks, nMismatch);
    if (nMismatch == 0 && numChecks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : giveVerdict

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    {wstrb, nrst, awvalid, wvalid, bready, arvalid, rready} = 10'h0;
    {awaddr, wdata, araddr} = {32'h0, 32'h0, 32'h0};
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    expectStatus(32'h0);
    axiWrite({28'h0, usb_event_pkg::OFS_MASK}, 32'hff, rs);
    axiRead({28'h0, usb_event_pkg::OFS_MASK}, rd, rs);
    check("mask", 32'hfd, rd);
    // Suspend, resume and host frame, each alone and unmasked: flag and interrupt
    for (int i = 0; i < 3; i++) begin
      PM.fire(evIdx[i]);
      @(negedge clk);
      check("irq set", 32'h1, {31'h0, irq});
      expectStatus(32'h1 << evBit[i]);
    end
    PM.fire(0);
    PM.fire(1);
    expectStatus(32'h04);
    PM.fire(0);
    PM.fire(0);
    expectStatus(32'h05);
    PM.fire(1);
    // Masked off: no interrupt; status writes change nothing
    axiWrite({28'h0, usb_event_pkg::OFS_MASK}, 32'h0, rs);
    PM.fire(4);
    @(negedge clk);
    check("irq masked", 32'h0, {31'h0, irq});
    axiWrite({28'h0, usb_event_pkg::OFS_STATUS}, 32'h0, rs);
    check("status wr resp", {30'h0, usb_event_pkg::RESP_OKAY}, {30'h0, rs});
    expectStatus(32'h40);
    // Vector write clears every flag
    PM.fire(3);
    PM.fire(0);
    axiWrite({28'h0, usb_event_pkg::OFS_VECTOR}, 32'h0, rs);
    expectStatus(32'h0);
    PM.fire(1);
    // Unmapped offset answers with an error
    axiWrite(32'h2, 32'hff, rs);
    check("unmapped wr", {30'h0, usb_event_pkg::RESP_SLVERR}, {30'h0, rs});
    axiRead(32'h2, rd, rs);
    check("unmapped rd", {30'h0, usb_event_pkg::RESP_SLVERR}, {30'h0, rs});
    // Unlocked timer: pseudo frame one period after the host frame
    PM.fire(2);
    PM.setLock(1'b0);
    expectStatus(32'h10);
    repeat (PERIOD - 10) @(posedge clk);
    expectStatus(32'h0);
    repeat (10) @(posedge clk);
    expectStatus(32'h08);
    PM.setLock(1'b1);
    // Bus reset with and without the reset output enabled
    for (int e = 1; e >= 0; e--) begin
      axiWrite({28'h0, usb_event_pkg::OFS_CONTROL}, e, rs);
      PM.setBusReset(1'b1);
      repeat (3) @(negedge clk);
      check("logic reset", 32'h1, {31'h0, usbLogicReset});
      check("reset pin", e, {31'h0, resetOutputPin});
      PM.setBusReset(1'b0);
      expectStatus(32'h80);
    end
    giveVerdict();
  end
endmodule : tb_top
